/* File: rtl/gsp_top.sv */
// generic serial port controller housekeeping, link shifter and dma channels
`timescale 1ns/1ps
`default_nettype none
`include "gsp_regs.svh"
module gsp_top
#(
   parameter int         NCH     = 2,
   parameter int         LW      = 7,
   parameter logic [9:0] LTR_ACT = `GSP_LTR_ACT_DEF
)
(
   // clocks and reset
   input  wire logic                   mclk,
   input  wire logic                   reset,
   input  wire logic                   link_clk,
   // software reset control
   input  wire logic                   sw_rst_wr,
   input  wire logic                   sw_rst_val,
   output logic                        ctl_rst_r,
   // dma channel configuration and memory port
   input  wire gsp_pkg::gsp_chan_cfg_t chan_cfg [NCH],
   output var gsp_pkg::gsp_xfer_t      chan_xfer_r [NCH],
   input  wire logic [NCH-1:0]         chan_xfer_ready,
   input  wire logic [31:0]            chan_rd_data [NCH],
   output logic [NCH-1:0]              chan_clk_req_r,
   // fifo levels and thresholds
   input  wire logic [LW-1:0]          tx_level,
   input  wire logic [LW-1:0]          rx_level,
   input  wire logic [LW-1:0]          tx_thresh,
   input  wire logic [LW-1:0]          rx_thresh,
   input  wire logic [1:0]             dma_req_en,
   input  wire logic                   rx_full,
   // word stream to and from the shifter
   input  wire logic                   tx_valid,
   input  wire logic [31:0]            tx_data,
   input  wire logic [4:0]             data_bits,
   input  wire logic                   cs_sel,
   output logic                        tx_ready_r,
   output logic                        rx_valid_r,
   output logic [31:0]                 rx_data_r,
   // interrupt status and control
   input  wire logic [3:0]             int_mask,
   input  wire logic [3:0]             int_clr,
   input  wire logic [NCH-1:0]         txdone_clr,
   output logic [3:0]                  int_status_r,
   output logic [NCH-1:0]              txdone_r,
   output logic                        irq_r,
   // latency tolerance report
   input  wire logic                   ltr_sw_mode,
   input  wire logic [9:0]             ltr_sw_val,
   output var gsp_pkg::gsp_ltr_t       ltr_r,
   // power gating and serial pins
   input  wire logic                   pwr_gate,
   output logic                        sclk_r,
   output logic [1:0]                  cs_n_r,
   output logic                        mosi_r,
   input  wire logic                   miso
);
   logic                      rst_i;
   logic [1:0]                hs_r;
   logic [NCH-1:0]            chan_done;
   logic [NCH-1:0]            chan_busy;
   logic [3:0]                is_set;
   logic                      busy;
   // handshake between the domains
   logic                      req_r;
   logic                      ack_r;
   logic                      ack_q_r;
   logic                      ack_ev;
   gsp_pkg::gsp_frame_t       frame_r;
   logic [1:0]                m_s;
   logic                      ack_s;
   logic                      m_gate;
   // link domain
   logic [3:0]                l_s;
   logic                      l_rst;
   logic                      l_req;
   logic                      l_gate;
   logic                      l_miso;
   gsp_pkg::gsp_link_st_t     lst_r;
   logic                      seen_r;
   logic                      ph_r;
   logic [4:0]                cnt_r;
   logic [31:0]               sh_r;
   logic [31:0]               rsh_r;

   // dma and controller share one software reset
   assign rst_i = reset || ctl_rst_r;

   // ----------------------------------------
   // software reset
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (reset)
         ctl_rst_r <= `GSP_CTL_RST_INIT;
      else if (sw_rst_wr)
         ctl_rst_r <= sw_rst_val;
   end

   // ----------------------------------------
   // dma channels
   // ----------------------------------------
   for (genvar i = 0; i < NCH; i++)
   begin : g_chan
      gsp_dma_chan u_chan
      (
         .mclk       (mclk),
         .reset      (rst_i),
         .cfg        (chan_cfg[i]),
         .hs_req     (hs_r),
         .xfer_r     (chan_xfer_r[i]),
         .xfer_ready (chan_xfer_ready[i]),
         .rd_data    (chan_rd_data[i]),
         .done_r     (chan_done[i]),
         .busy_r     (chan_busy[i])
      );
   end

   // disabled channel lets the platform stop its clock
   always_ff @(posedge mclk)
   begin
      if (rst_i)
         chan_clk_req_r <= '0;
      else
         for (int i = 0; i < NCH; i++)
            chan_clk_req_r[i] <= chan_cfg[i].en;
   end

   // ----------------------------------------
   // fifo threshold service requests
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst_i)
         hs_r <= '0;
      else
         hs_r <= {rx_level > rx_thresh, tx_level < tx_thresh} & dma_req_en;
   end

   // ----------------------------------------
   // word handshake, system side
   // ----------------------------------------
   gsp_sync #(.W(2)) u_to_m
   (
      .clk (mclk),
      .d   ({ack_r, pwr_gate}),
      .q_r (m_s)
   );
   assign ack_s  = m_s[1];
   assign m_gate = m_s[0];
   assign ack_ev = ack_s != ack_q_r;

   always_ff @(posedge mclk)
   begin
      if (rst_i)
      begin
         req_r      <= 1'b0;
         ack_q_r    <= 1'b0;
         tx_ready_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_data_r  <= '0;
         frame_r    <= '0;
      end
      else
      begin
         ack_q_r    <= ack_s;
         // no new frame while gated, so the pins stay put
         tx_ready_r <= (req_r == ack_s) && !m_gate && !(tx_valid && tx_ready_r);
         if (tx_valid && tx_ready_r)
         begin
            frame_r <= '{cs: cs_sel, bits: data_bits, data: tx_data};
            req_r   <= !req_r;
         end
         rx_valid_r <= ack_ev;
         // shifter word is frozen until the next request
         if (ack_ev)
            rx_data_r <= rsh_r;
      end
   end

   // ----------------------------------------
   // interrupt status
   // ----------------------------------------
   always_comb
   begin
      is_set               = '0;
      is_set[`GSP_IS_TXLO] = tx_level < tx_thresh;
      is_set[`GSP_IS_RXHI] = rx_level > rx_thresh;
      is_set[`GSP_IS_OVR]  = ack_ev && rx_full;
      is_set[`GSP_IS_FRM]  = ack_ev;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge mclk)
   begin
      if (rst_i)
      begin
         int_status_r <= '0;
         txdone_r     <= '0;
         irq_r        <= 1'b0;
      end
      else
      begin
         int_status_r <= (int_status_r & ~int_clr) | is_set;
         txdone_r     <= (txdone_r & ~txdone_clr) | chan_done;
         irq_r        <= (|(int_status_r & int_mask)) || (|txdone_r);
      end
   end

   // ----------------------------------------
   // latency tolerance report
   // ----------------------------------------
   assign busy = (req_r != ack_s) || (|chan_busy);

   always_ff @(posedge mclk)
   begin
      if (rst_i)
         ltr_r <= '0;
      else if (ltr_sw_mode)
         ltr_r <= '{req: 1'b1, value: ltr_sw_val};
      else if (busy)
         ltr_r <= '{req: 1'b1, value: LTR_ACT};
      else
         ltr_r <= '0;
   end

   // ----------------------------------------
   // serial shifter, link domain
   // ----------------------------------------
   gsp_sync #(.W(4)) u_to_link
   (
      .clk (link_clk),
      .d   ({ctl_rst_r, req_r, pwr_gate, miso}),
      .q_r (l_s)
   );
   assign l_rst  = l_s[3];
   assign l_req  = l_s[2];
   assign l_gate = l_s[1];
   assign l_miso = l_s[0];

   // a reset during power gating is deferred so the reset never moves the pins; a running frame still shifts to its end
   always_ff @(posedge link_clk)
   begin
      if (l_rst && !l_gate)
      begin
         lst_r  <= gsp_pkg::GSP_L_IDLE;
         sclk_r <= `GSP_SCLK_IDLE;
         cs_n_r <= `GSP_CS_IDLE;
         mosi_r <= `GSP_MOSI_IDLE;
         ack_r  <= 1'b0;
         seen_r <= 1'b0;
         ph_r   <= 1'b0;
         cnt_r  <= '0;
         sh_r   <= '0;
         rsh_r  <= '0;
      end
      else
         case (lst_r)
            gsp_pkg::GSP_L_IDLE:
               if ((l_req != seen_r) && !l_gate)
               begin
                  lst_r              <= gsp_pkg::GSP_L_SHIFT;
                  seen_r             <= l_req;
                  cnt_r              <= frame_r.bits;
                  sh_r               <= frame_r.data << (5'd31 - frame_r.bits);
                  mosi_r             <= frame_r.data[frame_r.bits];
                  cs_n_r[frame_r.cs] <= 1'b0;
                  rsh_r              <= '0;
                  ph_r               <= 1'b0;
               end
            gsp_pkg::GSP_L_SHIFT:
            begin
               ph_r <= !ph_r;
               if (!ph_r)
               begin
                  sclk_r <= 1'b1;
                  // pin is two link clocks late: the first rise still sees the idle line
                  if (cnt_r != frame_r.bits)
                     rsh_r <= {rsh_r[30:0], l_miso};
               end
               else
               begin
                  sclk_r <= 1'b0;
                  sh_r   <= sh_r << 1;
                  mosi_r <= sh_r[30];
                  cnt_r  <= cnt_r - 5'd1;
                  if (cnt_r == 5'd0)
                     lst_r <= gsp_pkg::GSP_L_END;
               end
            end
            gsp_pkg::GSP_L_END:
            begin
               cs_n_r <= `GSP_CS_IDLE;
               mosi_r <= `GSP_MOSI_IDLE;
               rsh_r  <= {rsh_r[30:0], l_miso};
               ack_r  <= !ack_r;
               lst_r  <= gsp_pkg::GSP_L_IDLE;
            end
            default:
               lst_r <= gsp_pkg::GSP_L_IDLE;
         endcase
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_rst_hold;
      @(posedge mclk)
      reset ##1 (!reset && !sw_rst_wr)[*2] |-> ctl_rst_r;
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("left reset without a write");

   property p_sw_rst;
      @(posedge mclk) disable iff (reset)
      sw_rst_wr |=> ctl_rst_r == $past(sw_rst_val);
   endproperty
   a_sw_rst: assert property (p_sw_rst) else $error("reset register write ignored");

   property p_irq_level;
      @(posedge mclk) disable iff (rst_i)
      (|txdone_r) |=> irq_r;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not held");

   property p_sw_clear;
      @(posedge mclk) disable iff (rst_i)
      int_status_r[`GSP_IS_OVR] && !int_clr[`GSP_IS_OVR] |=> int_status_r[`GSP_IS_OVR];
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("status cleared by itself");

   property p_ltr_sw;
      @(posedge mclk) disable iff (rst_i)
      ltr_sw_mode |=> ltr_r.req && (ltr_r.value == $past(ltr_sw_val));
   endproperty
   a_ltr_sw: assert property (p_ltr_sw) else $error("software latency not reported");

   property p_ltr_idle;
      @(posedge mclk) disable iff (rst_i)
      !ltr_sw_mode && !busy |=> !ltr_r.req;
   endproperty
   a_ltr_idle: assert property (p_ltr_idle) else $error("latency reported while idle");

   property p_dma_req;
      @(posedge mclk) disable iff (rst_i)
      (tx_level < tx_thresh) && dma_req_en[0] |=> hs_r[0];
   endproperty
   a_dma_req: assert property (p_dma_req) else $error("threshold request missing");

   property p_gate_hold;
      @(posedge link_clk)
      l_gate && (lst_r == gsp_pkg::GSP_L_IDLE) |=> $stable({sclk_r, cs_n_r, mosi_r});
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("pin moved while gated");

   property p_overrun;
      @(posedge mclk) disable iff (rst_i)
      ack_ev && rx_full |=> int_status_r[`GSP_IS_OVR] && rx_valid_r;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule : gsp_top
`default_nettype wire

/* File: rtl/gsp_regs.svh */
// constants of the generic serial port dma and control block
// Summary of operation
// - source and destination widths 1, 2, 4 bytes
// - burst lengths power of two up to 128
// - per-channel enable; disabled channel requests clock off
// - block length in bytes; pack and unpack widths
// - incrementing or constant address per side
// - any handshake request mapped to any channel
// - early stop of one channel only
// - own software reset register per instance
// - held in reset until software releases it
// - serial pins hold idle levels while gated; a frame already shifting when the gate arrives still runs to its end
// - latency requirement reported through dedicated outputs
// - hardware scheme: active while busy, none idle
// - software scheme sets the reported latency
// - one interrupt; readable status and completion
// - pending interrupt cleared only by software
// - interrupt active high, level, until cleared
// - serial-side errors exposed in status
// - clock, two selects, data out, data in
// - fifo threshold raises interrupt or dma request
// - one fifo entry of 1, 2, 4 bytes per access
// - peripheral handshake paces the flow
`ifndef GSP_REGS_SVH
`define GSP_REGS_SVH
// width codes of the data_size_select_field
`define GSP_W1 2'h0
`define GSP_W2 2'h1
`define GSP_W4 2'h2
// reset values and default active latency
`define GSP_CTL_RST_INIT 1'h1
`define GSP_LTR_ACT_DEF  10'h03C
`define GSP_CS_IDLE      2'h3
`define GSP_SCLK_IDLE    1'h0
`define GSP_MOSI_IDLE    1'h0
// interrupt status bit positions
`define GSP_IS_TXLO 0
`define GSP_IS_RXHI 1
`define GSP_IS_OVR  2
`define GSP_IS_FRM  3
`endif

/* File: rtl/gsp_pkg.sv */
// types shared by the generic serial port dma and control block
package gsp_pkg;
   typedef struct packed {
      logic        en;
      logic        abort;
      logic [1:0]  src_w;
      logic [1:0]  dst_w;
      logic [2:0]  src_blog;
      logic [2:0]  dst_blog;
      logic        src_inc;
      logic        dst_inc;
      logic        src_per;
      logic        hs_sel;
      logic [15:0] block_bytes;
      logic [31:0] src_addr;
      logic [31:0] dst_addr;
   } gsp_chan_cfg_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] data;
      logic        last;
   } gsp_xfer_t;
   typedef struct packed {
      logic        req;
      logic [9:0]  value;
   } gsp_ltr_t;
   typedef struct packed {
      logic        cs;
      logic [4:0]  bits;
      logic [31:0] data;
   } gsp_frame_t;
   typedef enum logic [3:0] {
      GSP_IDLE = 4'b0001,
      GSP_WAIT = 4'b0010,
      GSP_RUN  = 4'b0100,
      GSP_DONE = 4'b1000
   } gsp_dma_st_t;
   typedef enum logic [2:0] {
      GSP_L_IDLE  = 3'b001,
      GSP_L_SHIFT = 3'b010,
      GSP_L_END   = 3'b100
   } gsp_link_st_t;
endpackage : gsp_pkg

/* File: rtl/gsp_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module gsp_sync
#(
   parameter int W = 1
)
(
   // destination clock
   input  wire logic         clk,
   // asynchronous levels in, synchronised out
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q_r
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk)
   begin
      meta_r <= d;
      q_r    <= meta_r;
   end
endmodule : gsp_sync
`default_nettype wire

/* File: rtl/gsp_dma_chan.sv */
// one dma channel: packing, address modes, burst pacing, early stop
`timescale 1ns/1ps
`default_nettype none
`include "gsp_regs.svh"
module gsp_dma_chan
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   reset,
   // configuration and pacing
   input  wire gsp_pkg::gsp_chan_cfg_t cfg,
   input  wire logic [1:0]             hs_req,
   // memory-side transfer port
   output var gsp_pkg::gsp_xfer_t      xfer_r,
   input  wire logic                   xfer_ready,
   input  wire logic [31:0]            rd_data,
   // status
   output logic                        done_r,
   output logic                        busy_r
);
   gsp_pkg::gsp_dma_st_t st_r;
   logic [15:0] rrem_r;
   logic [15:0] wrem_r;
   logic [2:0]  held_r;
   logic [31:0] pack_r;
   logic [31:0] sa_r;
   logic [31:0] da_r;
   logic [7:0]  pbeat_r;
   logic [7:0]  mbeat_r;
   logic        pace_r;
   logic [2:0]  sw;
   logic [2:0]  dw;
   logic [7:0]  plast;
   logic [7:0]  mlast;
   logic        beat_done;
   logic        per_beat;
   logic        issue_rd;
   logic        nxt_per;
   logic        stop;

   assign sw        = 3'(3'h1 << cfg.src_w);
   assign dw        = 3'(3'h1 << cfg.dst_w);
   assign plast     = 8'(8'h01 << (cfg.src_per ? cfg.src_blog : cfg.dst_blog)) - 8'h01;
   assign mlast     = 8'(8'h01 << (cfg.src_per ? cfg.dst_blog : cfg.src_blog)) - 8'h01;
   assign beat_done = xfer_r.valid && xfer_ready;
   assign per_beat  = beat_done && (xfer_r.write != cfg.src_per);
   assign issue_rd  = (rrem_r != 16'h0000) && (held_r < dw);
   assign nxt_per   = issue_rd ? cfg.src_per : !cfg.src_per;
   // a ragged tail that cannot fill a write goes out in one full-width write rather than hang
   assign stop      = cfg.abort || !cfg.en || (wrem_r == 16'h0000)
                      || ((rrem_r == 16'h0000) && (held_r == 3'h0));

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         st_r   <= gsp_pkg::GSP_IDLE;
         done_r <= 1'b0;
         busy_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         busy_r <= (st_r == gsp_pkg::GSP_WAIT) || (st_r == gsp_pkg::GSP_RUN);
         case (st_r)
            gsp_pkg::GSP_IDLE:
               if (cfg.en)
                  st_r <= gsp_pkg::GSP_WAIT;
            gsp_pkg::GSP_WAIT:
               if (stop)
               begin
                  st_r   <= gsp_pkg::GSP_DONE;
                  done_r <= 1'b1;
               end
               else if (hs_req[cfg.hs_sel])
                  st_r <= gsp_pkg::GSP_RUN;
            gsp_pkg::GSP_RUN:
               if (!xfer_r.valid && stop)
               begin
                  st_r   <= gsp_pkg::GSP_DONE;
                  done_r <= 1'b1;
               end
               else if (!xfer_r.valid && pace_r && nxt_per)
                  st_r <= gsp_pkg::GSP_WAIT;
            gsp_pkg::GSP_DONE:
               if (!cfg.en)
                  st_r <= gsp_pkg::GSP_IDLE;
            default:
               st_r <= gsp_pkg::GSP_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // data path and counters
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         xfer_r  <= '0;
         rrem_r  <= '0;
         wrem_r  <= '0;
         held_r  <= '0;
         pack_r  <= '0;
         sa_r    <= '0;
         da_r    <= '0;
         pbeat_r <= '0;
         mbeat_r <= '0;
         pace_r  <= 1'b0;
      end
      else
      begin
         if (st_r == gsp_pkg::GSP_IDLE)
         begin
            sa_r    <= cfg.src_addr;
            da_r    <= cfg.dst_addr;
            rrem_r  <= cfg.block_bytes;
            wrem_r  <= cfg.block_bytes;
            held_r  <= '0;
            pack_r  <= '0;
            mbeat_r <= '0;
         end
         if ((st_r == gsp_pkg::GSP_WAIT) && hs_req[cfg.hs_sel])
         begin
            pbeat_r <= '0;
            pace_r  <= 1'b0;
         end
         if ((st_r == gsp_pkg::GSP_RUN) && !xfer_r.valid && !stop && !(pace_r && nxt_per))
         begin
            xfer_r.valid <= 1'b1;
            xfer_r.write <= !issue_rd;
            xfer_r.size  <= issue_rd ? cfg.src_w : cfg.dst_w;
            xfer_r.addr  <= issue_rd ? sa_r : da_r;
            xfer_r.data  <= pack_r;
            xfer_r.last  <= (nxt_per == 1'b0) && (mbeat_r == mlast);
         end
         if (beat_done)
         begin
            xfer_r.valid <= 1'b0;
            if (!xfer_r.write)
            begin
               pack_r <= pack_r | 32'((rd_data & ~(32'hFFFF_FFFF << {sw, 3'b000}))
                                      << {held_r, 3'b000});
               held_r <= held_r + sw;
               rrem_r <= (rrem_r > 16'(sw)) ? rrem_r - 16'(sw) : 16'h0000;
               if (cfg.src_inc)
                  sa_r <= sa_r + 32'(sw);
            end
            else
            begin
               pack_r <= pack_r >> {dw, 3'b000};
               held_r <= (held_r > dw) ? held_r - dw : 3'h0;
               wrem_r <= (wrem_r > 16'(dw)) ? wrem_r - 16'(dw) : 16'h0000;
               if (cfg.dst_inc)
                  da_r <= da_r + 32'(dw);
            end
            if (per_beat)
            begin
               pbeat_r <= pbeat_r + 8'h01;
               if (pbeat_r == plast)
                  pace_r <= 1'b1;
            end
            else
               mbeat_r <= (mbeat_r == mlast) ? 8'h00 : mbeat_r + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_hold_xfer;
      @(posedge mclk) disable iff (reset)
      xfer_r.valid && !xfer_ready |=> xfer_r.valid && $stable(xfer_r.addr);
   endproperty
   a_hold_xfer: assert property (p_hold_xfer) else $error("access dropped before ready");

   property p_abort_stop;
      @(posedge mclk) disable iff (reset)
      (st_r == gsp_pkg::GSP_RUN) && !xfer_r.valid && cfg.abort
      |=> (st_r == gsp_pkg::GSP_DONE) && done_r ##1 !xfer_r.valid;
   endproperty
   a_abort_stop: assert property (p_abort_stop) else $error("abort did not stop channel");

   property p_const_src;
      @(posedge mclk) disable iff (reset)
      beat_done && !xfer_r.write && !cfg.src_inc |=> $stable(sa_r);
   endproperty
   a_const_src: assert property (p_const_src) else $error("constant source address moved");
endmodule : gsp_dma_chan
`default_nettype wire

/* File: tb/gsp_periph.sv */
// far side model: serial peripheral on select 0 and a memory port
`timescale 1ns/1ps
`default_nettype none
module gsp_periph
#(
   parameter logic [31:0] PAT = 32'ha5c3_0f96
)
(
   // serial pins
   input  wire logic               sclk,
   input  wire logic [1:0]         cs_n,
   input  wire logic               mosi,
   output logic                    miso,
   output logic [31:0]             cap,
   // memory side, stall slows the answer
   input  wire gsp_pkg::gsp_xfer_t xfer,
   input  wire logic               stall,
   output logic                    ready,
   output logic [31:0]             rd_data
);
   logic [31:0] sh_r = PAT;
   always @(posedge sclk) cap <= {cap[30:0], mosi};
   always @(negedge sclk or posedge cs_n[0])
      if (cs_n[0]) sh_r <= PAT;
      else sh_r <= {sh_r[30:0], 1'b0};
   // deselected line falls to its pull-down
   assign miso = cs_n[0] ? 1'b0 : sh_r[31];
   assign ready = xfer.valid & ~stall;
   assign rd_data = xfer.addr ^ 32'h5a5a_5a5a;
endmodule : gsp_periph
`default_nettype wire

/* File: tb/tb.sv */
// bench: reset, latency report, frame, interrupt, gating, dma blocks
`timescale 1ns/1ps
`default_nettype none
`include "gsp_regs.svh"
module tb;
   logic mclk = 0, link_clk = 0, reset = 1, sw_rst_wr = 0, sw_rst_val = 1, stall = 0;
   logic ctl, rdy, txv = 0, txr, rxv, irq, lmode = 0, gate = 0, sclk, mosi, miso, csel = 0;
   gsp_pkg::gsp_chan_cfg_t cfg [2];
   gsp_pkg::gsp_xfer_t     xf [2];
   gsp_pkg::gsp_ltr_t      latency_tolerance_report;
   logic [31:0] cap, rx_data_r, w, a, pk, seed = 32'h8613_772f;
   wire  [31:0] rd [2];
   logic        rf = 0;
   logic [9:0]  lval = 0;
   logic [6:0]  txl = 0, th = 7'h08;
   logic [4:0]  db = 5'h07;
   logic [3:0]  imask = 4'h8, iclr = 0, ist;
   logic [1:0]  cs_n, creq, tdone, tdclr = 0;
   logic [66:0] exp_q [$];
   int          errors = 0, tests_run = 0, n, m;
   gsp_top #(.NCH(2)) i_gsp_top (.mclk, .reset, .link_clk, .sw_rst_wr, .sw_rst_val,
      .ctl_rst_r(ctl), .chan_cfg(cfg), .chan_xfer_r(xf), .chan_xfer_ready({1'b0, rdy}),
      .chan_rd_data(rd), .chan_clk_req_r(creq), .tx_level(txl), .rx_level(txl), .tx_thresh(th),
      .rx_thresh(th), .dma_req_en(2'h1), .rx_full(rf), .tx_valid(txv), .tx_data(w),
      .data_bits(db), .cs_sel(csel), .tx_ready_r(txr), .rx_valid_r(rxv), .rx_data_r,
      .int_mask(imask), .int_clr(iclr), .txdone_clr(tdclr), .int_status_r(ist),
      .txdone_r(tdone), .irq_r(irq), .ltr_sw_mode(lmode), .ltr_sw_val(lval), .ltr_r(latency_tolerance_report),
      .pwr_gate(gate), .sclk_r(sclk), .cs_n_r(cs_n), .mosi_r(mosi), .miso);
   gsp_periph i_gsp_periph (.sclk, .cs_n, .mosi, .miso, .cap, .xfer(xf[0]), .stall,
      .ready(rdy), .rd_data(rd[0]));
   assign rd[1] = 32'h0000_0000;
   task automatic chk(string nm, logic [66:0] e, logic [66:0] s);
      tests_run++;
      if (e !== s)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic tick(int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : tick
   initial forever #5 mclk = ~mclk;
   // link clock phase unrelated to mclk
   initial
   begin
      #3;
      forever #6 link_clk = ~link_clk;
   end
   always @(posedge mclk) stall <= #1 $random(seed);
   always @(posedge mclk)
      if (xf[0].valid && rdy)
         chk("xfer", exp_q.size() ? exp_q.pop_front() : '1, {xf[0].write, xf[0].size,
            xf[0].addr, xf[0].write ? xf[0].data : 32'h0000_0000});
   initial
   begin
      #100000;
      errors++;
      tally_and_finish;
   end
   initial
   begin
      cfg[0] = '0;
      cfg[1] = '0;
      w = $random(seed);
      tick(8);
      reset = 0;
      chk("held", 1, ctl);
      sw_rst_wr = 1;
      sw_rst_val = 0;
      tick(1);
      sw_rst_wr = 0;
      chk("release", 0, ctl);
      lmode = 1;
      lval = $random(seed);
      tick(2);
      chk("ltr_sw", lval, latency_tolerance_report.value);
      lmode = 0;
      tick(2);
      chk("ltr_idle", 0, latency_tolerance_report.req);
      rf = 1;
      txv = 1;
      n = 0;
      do tick(1); while (txr !== 1'b1 && ++n < 50);
      tick(1);
      txv = 0;
      tick(4);
      chk("ltr_busy", {1'b1, `GSP_LTR_ACT_DEF}, latency_tolerance_report);
      n = 0;
      do tick(1); while (rxv !== 1'b1 && ++n < 200);
      chk("rx", 32'h0000_00a5, rx_data_r);
      chk("tx", w[7:0], cap[7:0]);
      chk("ovr", 1, ist[`GSP_IS_OVR]);
      rf = 0;
      tick(3);
      chk("irq", 1, irq);
      iclr = 4'h8;
      tick(1);
      iclr = 0;
      tick(2);
      chk("irq_clr", 0, irq);
      gate = 1;
      tick(6);
      chk("gate", 5'h0c, {txr, cs_n, sclk, mosi});
      gate = 0;
      // third block is stopped right after its first read
      for (m = 0; m < 3; m++)
      begin
         a = $random(seed) & 32'h00ff_fff0;
         for (n = 0; n < (m == 2 ? 1 : 4); n++)
         begin
            exp_q.push_back({3'h0, a + (m ? 0 : n), 32'h0000_0000});
            pk[8*n +: 8] = 8'(a + (m ? 0 : n)) ^ 8'h5a;
         end
         if (m < 2)
            exp_q.push_back({1'b1, 2'h2, 32'h0000_2000, pk});
         cfg[0] = '{en: 1, src_w: 0, dst_w: 2, src_inc: (m == 0), dst_inc: 1,
            block_bytes: 16'h0004, src_addr: a, dst_addr: 32'h0000_2000, default: 0};
         n = 0;
         if (m == 2)
         begin
            do tick(1); while (exp_q.size() && ++n < 300);
            cfg[0].abort = 1;
         end
         do tick(1); while (tdone[0] !== 1'b1 && ++n < 300);
         chk("left", 0, exp_q.size());
         chk("clk_req", 1, creq[0]);
         tick(1);
         chk("done_irq", 1, irq);
         tdclr = 2'h1;
         cfg[0].en = 0;
         tick(1);
         tdclr = 0;
         tick(3);
         chk("done_clr", 0, {irq, tdone, creq});
      end
      tally_and_finish;
   end
endmodule : tb
`default_nettype wire
